// ==== verilog/sent_pkg.sv ====
// shared constants and types for the shared single-wire sensor link
package sent_pkg;
    // clock and tick timing
    localparam int CLK_MHZ = 250;
    localparam int TICK_NS = 3000;
    localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;
    localparam int TRIG_MIN_NS = 1800;
    localparam int TRIG_MIN_CYC = (TRIG_MIN_NS * CLK_MHZ + 999) / 1000;
    // output mode codes
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_STREAM = 3'h1;
    localparam logic [2:0] MODE_SYNCED = 3'h2;
    localparam logic [2:0] MODE_TRIG_SCN = 3'h3;
    localparam logic [2:0] MODE_TRIG_FALL = 3'h4;
    localparam logic [2:0] MODE_ADDR = 3'h5;
    localparam logic [2:0] MODE_SEQ = 3'h6;
    localparam logic [2:0] MODE_LSEQ = 3'h7;
    // frame timing in ticks and the status nibble value
    localparam logic [9:0] LOW_TICKS = 10'h005;
    localparam logic [9:0] SYNC_TICKS = 10'h038;
    localparam logic [9:0] NIB_BASE = 10'h00c;
    localparam logic [9:0] PAUSE_MIN = 10'h00c;
    localparam logic [9:0] PAUSE_MAX = 10'h300;
    localparam logic [9:0] TRESP_TICKS = 10'h002;
    localparam logic [9:0] SAMPLE_TICK = 10'h001;
    localparam logic [3:0] STATUS_NIB = 4'h0;
    // function pulse windows, modes 5 and 6; the sync window in mode 6 only
    localparam logic [9:0] OUT_MIN = 10'h00f;
    localparam logic [9:0] OUT_MAX = 10'h013;
    localparam logic [9:0] SMP_MIN = 10'h01f;
    localparam logic [9:0] SMP_MAX = 10'h027;
    localparam logic [9:0] DIAG_MIN = 10'h038;
    localparam logic [9:0] DIAG_MAX = 10'h046;
    localparam logic [9:0] SYNC_MIN = 10'h05d;
    localparam logic [9:0] SYNC_MAX = 10'h073;
    // function pulse windows, mode 7
    localparam logic [9:0] LOUT_MIN = 10'h009;
    localparam logic [9:0] LOUT_MAX = 10'h051;
    localparam logic [9:0] LSYNC_MIN = 10'h069;
    localparam logic [9:0] LSYNC_MAX = 10'h0ab;
    localparam logic [9:0] LDIAG_MIN = 10'h0d8;
    localparam logic [9:0] LDIAG_MAX = 10'h108;
    // host register map
    localparam logic [11:0] REG_CMD = 12'h000;
    localparam logic [11:0] REG_STAT = 12'h004;
    localparam logic [9:0] CMD_RESET = 10'h000;

    typedef enum logic [2:0] {
        F_NONE = 3'b000,
        F_OUT = 3'b001,
        F_SAMP = 3'b010,
        DIAGNOSTIC_FUNCTION_PULSE = 3'b011,
        F_SYNC = 3'b100
    } func_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_DELAY = 2'b01,
        TX_PULSE = 2'b10
    } tx_state_t;
endpackage

// ==== verilog/sent_if.sv ====
// open-drain shared line joining the sensor end and the host end
`timescale 1ns/1ps
interface sent_if;
    logic dev_out;
    logic dev_oe;
    logic host_out;
    logic host_oe;
    logic line;

    // pulled up unless some party drives low
    assign line = !((dev_oe && !dev_out) || (host_oe && !host_out));

    modport dev(input line, output dev_out, output dev_oe);
    modport host(input line, output host_out, output host_oe);
endinterface

// ==== verilog/sent_sensor_end.sv ====
// sensor end: frame sequencer, function pulse decoder and slot counter
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module sent_sensor_end
    import sent_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC // pclk cycles per tick
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    sent_if.dev link, // shared line
    input wire logic [2:0] output_mode_field, // output mode
    input wire logic [3:0] output_rate_setting, // angle update rate
    input wire logic [11:0] angle_in, // newest angle
    input wire logic angle_update, // pulse: angle_in refreshed
    input wire logic id_pin_low, // id bit 0 pin
    input wire logic id_pin_high, // id bit 1 pin
    input wire logic ignore_sample_pulse_option, // no hold on sample pulse
    input wire logic sample_pulse_addr_option, // sample pulse also addresses
    input wire logic first_slot_hold_option, // hold on slot 0 output
    input wire logic diag_pulse_addressing_option, // diag pulse addresses
    input wire logic diagnostics_permit_option, // diagnostics allowed
    input wire logic [1:0] bus_sensor_count, // highest slot before wrap
    input wire logic [6:0] output_pulse_min_adjust, // mode 7 output minimum
    output logic diag_start, // pulse: enter self-test
    output logic [1:0] slot_number, // current slot counter
    output logic tx_busy, // frame or delay in progress
    output logic [11:0] sent_angle // angle in the current frame
);
    logic ln_s1_ff, ln_s2_ff, ln_d_ff;
    logic [1:0] id_s1_ff, id_s2_ff;
    logic pull_ff;
    logic [2:0] own_ff;
    logic meas_ff;
    logic [15:0] lpre_ff, lcyc_ff;
    logic [9:0] lticks_ff;
    logic [1:0] slot_ff;
    logic [11:0] live_ff, held_ff, tx_ff;
    logic held_v_ff, fresh_ff, diag_ff, busy_ff;
    tx_state_t st_ff;
    logic [15:0] tpre_ff;
    logic [9:0] tk_ff;
    logic [2:0] nib_ff;
    logic fall, rise, host_fall, host_rel, tick_end, frame_end, pause_go;
    logic [9:0] len;
    logic [3:0] nib_val;
    func_t fn;
    logic addr_pls, hit, seqm, ev, hold_now, respond, trig;

    // classify a measured low against the windows of the active mode
    function automatic func_t decode_pulse(input logic [2:0] m, input logic [9:0] t, input logic [6:0] adj);
        logic [9:0] lo;
        func_t f;
        lo = (10'(adj) > LOUT_MIN) ? 10'(adj) : LOUT_MIN;
        f = F_NONE;
        if (m == MODE_ADDR || m == MODE_SEQ) begin
            if (t >= OUT_MIN && t <= OUT_MAX) f = F_OUT;
            else if (t >= SMP_MIN && t <= SMP_MAX) f = F_SAMP;
            else if (t >= DIAG_MIN && t <= DIAG_MAX) f = DIAGNOSTIC_FUNCTION_PULSE;
            else if (m == MODE_SEQ && t >= SYNC_MIN && t <= SYNC_MAX) f = F_SYNC;
        end else if (m == MODE_LSEQ) begin
            if (t >= lo && t <= LOUT_MAX) f = F_OUT;
            else if (t >= LSYNC_MIN && t <= LSYNC_MAX) f = F_SYNC;
            else if (t >= LDIAG_MIN && t <= LDIAG_MAX) f = DIAGNOSTIC_FUNCTION_PULSE;
        end
        return f;
    endfunction

    // two-stage synchronisers for the line and the id pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ln_s1_ff <= 1'b1;
            ln_s2_ff <= 1'b1;
            ln_d_ff <= 1'b1;
            id_s1_ff <= 2'h0;
            id_s2_ff <= 2'h0;
        end else begin
            ln_s1_ff <= link.line;
            ln_s2_ff <= ln_s1_ff;
            ln_d_ff <= ln_s2_ff;
            id_s1_ff <= {id_pin_high, id_pin_low};
            id_s2_ff <= id_s1_ff;
        end
    end

    // edges; lows we made ourselves are masked out
    assign fall = ln_d_ff && !ln_s2_ff;
    assign rise = !ln_d_ff && ln_s2_ff;
    assign host_fall = fall && !pull_ff && (own_ff == 3'h0);
    assign host_rel = meas_ff && rise;

    // history of our own pull, covers synchroniser lag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) own_ff <= 3'h0;
        else own_ff <= {own_ff[1:0], pull_ff};
    end

    // measure host low time in ticks and in cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_ff <= 1'b0;
            lpre_ff <= 16'h0;
            lcyc_ff <= 16'h0;
            lticks_ff <= 10'h0;
        end else if (host_fall) begin
            meas_ff <= 1'b1;
            lpre_ff <= 16'h1; // the edge cycle already counts as the first low cycle
            lcyc_ff <= 16'h1;
            lticks_ff <= 10'h0;
        end else if (meas_ff) begin
            if (rise) meas_ff <= 1'b0;
            if (lcyc_ff != 16'hffff) lcyc_ff <= lcyc_ff + 16'h1;
            if (lpre_ff == 16'(TICK_CYCLES - 1)) begin
                lpre_ff <= 16'h0;
                if (lticks_ff != 10'h3ff) lticks_ff <= lticks_ff + 10'h1;
            end else begin
                lpre_ff <= lpre_ff + 16'h1;
            end
        end
    end

    // decode a released host pulse into actions
    always_comb begin
        fn = decode_pulse(output_mode_field, lticks_ff, output_pulse_min_adjust);
        seqm = (output_mode_field == MODE_SEQ) || (output_mode_field == MODE_LSEQ);
        addr_pls = (fn == F_OUT) || (fn == F_SAMP && sample_pulse_addr_option) ||
                   (fn == DIAGNOSTIC_FUNCTION_PULSE && diag_pulse_addressing_option);
        hit = addr_pls && (slot_ff == id_s2_ff);
        ev = host_rel && (output_mode_field >= MODE_ADDR) && (st_ff == TX_IDLE);
        hold_now = ev && ((fn == F_SAMP && !ignore_sample_pulse_option) ||
                   (fn == F_OUT && seqm && first_slot_hold_option && slot_ff == 2'h0));
        respond = ev && hit && (fn == F_OUT || fn == F_SAMP);
        trig = host_rel && (st_ff == TX_IDLE) && (lcyc_ff >= 16'(TRIG_MIN_CYC)) &&
               (output_mode_field == MODE_TRIG_SCN || output_mode_field == MODE_TRIG_FALL);
    end

    // slot counter: sync to 0, advance on addressing pulses only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) slot_ff <= 2'h0;
        else if (ev && fn == F_SYNC) slot_ff <= 2'h0;
        else if (ev && addr_pls) slot_ff <= (slot_ff >= bus_sensor_count) ? 2'h0 : slot_ff + 2'h1;
    end

    // live angle and the sample-and-hold store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            live_ff <= 12'h0;
            held_ff <= 12'h0;
            held_v_ff <= 1'b0;
        end else begin
            if (angle_update) live_ff <= angle_in;
            if (hold_now) held_ff <= live_ff;
            held_v_ff <= respond ? 1'b0 : (hold_now ? 1'b1 : held_v_ff);
        end
    end

    // fresh-data flag for mode 2; a new update wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) fresh_ff <= 1'b0;
        else if (angle_update) fresh_ff <= 1'b1;
        else if (st_ff == TX_PULSE && nib_ff == 3'h0 && tk_ff == SAMPLE_TICK && tpre_ff == 16'h0) fresh_ff <= 1'b0;
    end

    // diagnostics entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) diag_ff <= 1'b0;
        else diag_ff <= ev && fn == DIAGNOSTIC_FUNCTION_PULSE && diagnostics_permit_option &&
                        (!diag_pulse_addressing_option || hit);
    end

    // nibble contents and pulse lengths
    always_comb begin
        unique case (nib_ff)
            3'h1: nib_val = STATUS_NIB;
            3'h2: nib_val = tx_ff[11:8];
            3'h3: nib_val = tx_ff[7:4];
            3'h4: nib_val = tx_ff[3:0];
            3'h5: nib_val = tx_ff[11:8] ^ tx_ff[7:4] ^ tx_ff[3:0] ^ STATUS_NIB;
            default: nib_val = 4'h0;
        endcase
        if (nib_ff == 3'h0) len = SYNC_TICKS;
        else if (nib_ff == 3'h6) len = (output_mode_field == MODE_SYNCED) ? PAUSE_MAX : LOW_TICKS;
        else len = NIB_BASE + 10'(nib_val);
    end

    assign tick_end = (tpre_ff == 16'(TICK_CYCLES - 1));
    assign frame_end = tick_end && (tk_ff + 10'h1 == len);
    assign pause_go = tick_end && nib_ff == 3'h6 && output_mode_field == MODE_SYNCED &&
                      fresh_ff && (tk_ff + 10'h1 >= PAUSE_MIN);

    // frame sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= TX_IDLE;
            tpre_ff <= 16'h0;
            tk_ff <= 10'h0;
            nib_ff <= 3'h0;
        end else if (output_mode_field == MODE_OFF) begin
            st_ff <= TX_IDLE;
            tpre_ff <= 16'h0;
            tk_ff <= 10'h0;
            nib_ff <= 3'h0;
        end else begin
            tpre_ff <= (st_ff == TX_IDLE || tick_end) ? 16'h0 : tpre_ff + 16'h1;
            unique case (st_ff)
                TX_IDLE: begin
                    tk_ff <= 10'h0;
                    nib_ff <= 3'h0;
                    if (output_mode_field == MODE_STREAM || (output_mode_field == MODE_SYNCED && fresh_ff))
                        st_ff <= TX_PULSE;
                    else if (trig || respond)
                        st_ff <= TX_DELAY;
                end
                TX_DELAY: begin
                    if (tick_end && tk_ff + 10'h1 == TRESP_TICKS) begin
                        st_ff <= TX_PULSE;
                        tk_ff <= 10'h0;
                    end else if (tick_end) begin
                        tk_ff <= tk_ff + 10'h1;
                    end
                end
                TX_PULSE: begin
                    if (pause_go) begin
                        tk_ff <= 10'h0;
                        nib_ff <= 3'h0;
                    end else if (frame_end) begin
                        tk_ff <= 10'h0;
                        if (nib_ff < 3'h5) nib_ff <= nib_ff + 3'h1;
                        else if (nib_ff == 3'h5) nib_ff <= (output_mode_field == MODE_STREAM) ? 3'h0 : 3'h6;
                        else if (output_mode_field != MODE_SYNCED) st_ff <= TX_IDLE;
                    end else if (tick_end) begin
                        tk_ff <= tk_ff + 10'h1; // pause reaching its maximum restarts above
                    end
                end
                default: st_ff <= TX_IDLE;
            endcase
        end
    end

    // angle carried by the frame, latched per mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tx_ff <= 12'h0;
        else if (st_ff == TX_PULSE && frame_end && nib_ff == 3'h1 &&
                 (output_mode_field == MODE_STREAM || output_mode_field == MODE_TRIG_SCN))
            tx_ff <= live_ff;
        else if (st_ff == TX_PULSE && nib_ff == 3'h0 && tk_ff == SAMPLE_TICK && tpre_ff == 16'h0 &&
                 output_mode_field == MODE_SYNCED)
            tx_ff <= live_ff;
        else if (host_fall && st_ff == TX_IDLE && output_mode_field == MODE_TRIG_FALL)
            tx_ff <= live_ff;
        else if (respond)
            tx_ff <= (hold_now || !held_v_ff) ? live_ff : held_ff;
    end

    // line pull and status outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            pull_ff <= (output_mode_field != MODE_OFF) && (st_ff == TX_PULSE) && (tk_ff < LOW_TICKS);
            busy_ff <= (st_ff != TX_IDLE);
        end
    end

    assign link.dev_out = 1'b0; // only ever pulls low
    assign link.dev_oe = pull_ff;
    assign diag_start = diag_ff;
    assign slot_number = slot_ff;
    assign tx_busy = busy_ff;
    assign sent_angle = tx_ff;
endmodule

// ==== verilog/sent_host_end.sv ====
// host end: APB-controlled function pulse generator on the shared line
`timescale 1ns/1ps
module sent_host_end
    import sent_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC // pclk cycles per tick
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    sent_if.host link // shared line
);
    logic ln_s1_ff, ln_s2_ff, ln_d_ff;
    logic [9:0] cmd_ff;
    logic [23:0] pcnt_ff;
    logic pull_ff;
    logic [2:0] own_ff;
    logic [7:0] edges_ff;
    logic [31:0] rdata_ff;
    logic rdy_ff, err_ff;
    logic acc, wr_fire, start, mapped;
    logic [23:0] want;

    assign acc = psel && penable && !rdy_ff;
    assign mapped = (paddr == REG_CMD) || (paddr == REG_STAT);
    assign wr_fire = psel && penable && pwrite && rdy_ff && (paddr == REG_CMD);
    assign start = wr_fire && !pull_ff && (pwdata[9:0] != 10'h0);
    // pulse length in cycles, never shorter than the trigger minimum
    assign want = (24'(pwdata[9:0]) * 24'(TICK_CYCLES) > 24'(TRIG_MIN_CYC)) ?
                  24'(pwdata[9:0]) * 24'(TICK_CYCLES) : 24'(TRIG_MIN_CYC);

    // line synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ln_s1_ff <= 1'b1;
            ln_s2_ff <= 1'b1;
            ln_d_ff <= 1'b1;
        end else begin
            ln_s1_ff <= link.line;
            ln_s2_ff <= ln_s1_ff;
            ln_d_ff <= ln_s2_ff;
        end
    end

    // apb answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_ff <= 1'b0;
            err_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            rdy_ff <= acc;
            err_ff <= acc && !mapped;
            if (acc && !pwrite)
                rdata_ff <= (paddr == REG_CMD) ? {22'h0, cmd_ff} :
                            (paddr == REG_STAT) ? {16'h0, edges_ff, 6'h0, ln_s2_ff, pull_ff} : 32'h0;
        end
    end

    // command register and low pulse timer; writes while busy are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ff <= CMD_RESET;
            pcnt_ff <= 24'h0;
            pull_ff <= 1'b0;
        end else if (start) begin
            cmd_ff <= pwdata[9:0];
            pcnt_ff <= want;
            pull_ff <= 1'b1;
        end else if (pull_ff) begin
            pcnt_ff <= pcnt_ff - 24'h1;
            if (pcnt_ff == 24'h1) pull_ff <= 1'b0;
        end
    end

    // count falling edges made by sensors since the last pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            own_ff <= 3'h0;
            edges_ff <= 8'h0;
        end else begin
            own_ff <= {own_ff[1:0], pull_ff};
            if (ln_d_ff && !ln_s2_ff && !pull_ff && own_ff == 3'h0 && edges_ff != 8'hff)
                edges_ff <= edges_ff + 8'h1;
            else if (start)
                edges_ff <= 8'h0; // sensor polling order is software's
        end
    end

    assign link.host_out = 1'b0; // open-drain
    assign link.host_oe = pull_ff;
    assign prdata = rdata_ff;
    assign pready = rdy_ff;
    assign pslverr = err_ff;
endmodule

// ==== sim/sent_link_monitor.sv ====
// assertions on the shared line and the sensor's slot and frame outputs
`timescale 1ns/1ps
module sent_link_monitor
    import sent_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC // pclk cycles per tick
) (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic dev_out, // sensor data
    input wire logic dev_oe, // sensor pulls
    input wire logic host_out, // host data
    input wire logic host_oe, // host pulls
    input wire logic line, // wired level
    input wire logic [2:0] output_mode_field, // mode
    input wire logic [1:0] bus_sensor_count, // wrap slot
    input wire logic [1:0] slot_number, // slot
    input wire logic tx_busy, // frame busy
    input wire logic diag_start // self-test pulse
);
    localparam int LOW_CYC = 5 * TICK_CYCLES;
    localparam int DMIN = 2 * TICK_CYCLES - 4;
    localparam int DMAX = 2 * TICK_CYCLES + 8;
    int hi_cnt_ff;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // counts cycles of each sensor low pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hi_cnt_ff <= 0;
        else hi_cnt_ff <= dev_oe ? hi_cnt_ff + 1 : 0;
    end

    sequence quiet_s;
        !dev_oe [*8];
    endsequence

    od_dev_a: assert property (dev_oe |-> !dev_out) else $error("sensor drives high");
    od_host_a: assert property (host_oe |-> !host_out) else $error("host drives high");
    idle_high_a: assert property (!dev_oe && !host_oe |-> line) else $error("released line low");
    mode_off_a: assert property (output_mode_field == MODE_OFF |-> !dev_oe) else $error("output in mode 0");
    pulse_len_a: assert property ($fell(dev_oe) |-> hi_cnt_ff == LOW_CYC) else $error("low not 5 ticks");
    resp_quiet_a: assert property ($fell(host_oe) |-> quiet_s) else $error("answer too early");
    resp_delay_a: assert property ($rose(tx_busy) && output_mode_field >= MODE_TRIG_SCN
        |-> ##[DMIN:DMAX] $rose(dev_oe)) else $error("frame start late");
    slot_step_a: assert property ($changed(slot_number) |-> slot_number == 2'h0 ||
        (slot_number == $past(slot_number) + 2'h1 && $past(slot_number) != bus_sensor_count))
        else $error("slot step wrong");
    diag_once_a: assert property (diag_start |=> !diag_start && !tx_busy) else $error("diag pulse wrong");
endmodule

// ==== sim/tb_top.sv ====
// bench joining host and sensor ends over the shared line
`timescale 1ns/1ps
module tb_top;
    import sent_pkg::*;
    localparam int TC = 30; // long enough that a 17-tick pulse outlasts the trigger minimum
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000, angle = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, diag_start, tx_busy, permit = 1'b1;
    logic [2:0] mode = 3'h0;
    logic [1:0] slot_number;
    logic [1:0] bsc = 2'h3;
    logic upd = 1'b0, id_lo = 1'b0, id_hi = 1'b1, saddr = 1'b0; // sensor id 2
    logic [11:0] sent_angle;
    int n_mismatch = 0, cmp_count = 0;
    sent_if link();

    always #2 pclk = ~pclk;

    sent_host_end #(.TICK_CYCLES(TC)) i_sent_host_end (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link.host));
    sent_sensor_end #(.TICK_CYCLES(TC)) i_sent_sensor_end (.pclk(pclk), .presetn(presetn),
        .link(link.dev), .output_mode_field(mode), .output_rate_setting(4'h0), .angle_in(angle),
        .angle_update(upd), .id_pin_low(id_lo), .id_pin_high(id_hi), .ignore_sample_pulse_option(1'b0),
        .sample_pulse_addr_option(saddr), .first_slot_hold_option(1'b0),
        .diag_pulse_addressing_option(1'b0), .diagnostics_permit_option(permit),
        .bus_sensor_count(bsc), .output_pulse_min_adjust(7'h00), .diag_start(diag_start),
        .slot_number(slot_number), .tx_busy(tx_busy), .sent_angle(sent_angle));
    sent_link_monitor #(.TICK_CYCLES(TC)) i_sent_link_monitor (.pclk(pclk), .presetn(presetn),
        .dev_out(link.dev_out), .dev_oe(link.dev_oe), .host_out(link.host_out), .host_oe(link.host_oe),
        .line(link.line), .output_mode_field(mode), .bus_sensor_count(bsc),
        .slot_number(slot_number), .tx_busy(tx_busy), .diag_start(diag_start));

    task automatic stop_test();
        if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) begin n_mismatch++; stop_test(); end
    endtask

    // host low pulse of tk ticks, then wait until any answer is over
    task automatic pulse(input int md, input int tk, output logic tx, output logic dg);
        logic [31:0] q;
        logic e;
        int n;
        int lim;
        mode <= md[2:0];
        apb(1'b1, REG_CMD, tk, q, e);
        tx = 0; dg = 0; n = 0;
        lim = (tk * TC > TRIG_MIN_CYC) ? tk * TC : TRIG_MIN_CYC; // host stretches short lows to the minimum
        while (n < 20000 && !(n > lim + 60 && link.line === 1'b1 && tx_busy === 1'b0)) begin
            @(posedge pclk);
            n++;
            if (tx_busy === 1'b1) tx = 1;
            if (diag_start === 1'b1) dg = 1;
        end
        if (n >= 20000) begin n_mismatch++; stop_test(); end
    endtask

    // shared-bus pulse sequence, sensor id 2, four slots
    task automatic t_shared();
        int md[11] = '{6, 6, 6, 6, 6, 6, 6, 6, 6, 7, 7};
        int tk[11] = '{17, 104, 17, 17, 17, 17, 35, 25, 63, 40, 140};
        int sl[11] = '{1, 0, 1, 2, 3, 0, 0, 0, 0, 1, 0};
        int fl[11] = '{0, 0, 0, 0, 1, 0, 0, 0, 2, 0, 0};
        logic tx, dg;
        for (int i = 0; i < 11; i++) begin
            pulse(md[i], tk[i], tx, dg);
            chk("slot", sl[i], slot_number);
            chk("answer", fl[i] == 1, tx);
            chk("diag", fl[i] == 2, dg);
        end
        // mode 5, sample pulse as addressing pulse, two-slot bus
        saddr <= 1'b1;
        bsc <= 2'h1;
        pulse(5, 35, tx, dg);
        chk("samp addr slot", 1, slot_number);
        pulse(5, 35, tx, dg);
        chk("count wrap", 0, slot_number);
        saddr <= 1'b0;
        bsc <= 2'h3;
    endtask

    // stop the sensor just after one of its lows so no low is cut short
    task automatic quiet_off();
        int n;
        n = 0;
        while (n < 2000 && link.dev_oe !== 1'b1) begin
            @(posedge pclk);
            n++;
        end
        while (n < 4000 && link.dev_oe !== 1'b0) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 4000) begin n_mismatch++; stop_test(); end
        mode <= MODE_OFF;
        repeat (4) @(posedge pclk);
        chk("off busy", 1'b0, tx_busy);
        chk("off line", 1'b1, link.line);
    endtask

    // free-running modes: back-to-back frames, then frames paced by angle updates
    task automatic t_stream();
        angle <= 12'h3c5;
        upd <= 1'b1;
        @(posedge pclk);
        upd <= 1'b0;
        mode <= MODE_STREAM;
        repeat (100 * TC) @(posedge pclk);
        chk("stream busy", 1'b1, tx_busy);
        chk("stream angle", 12'h3c5, sent_angle);
        quiet_off();
        mode <= MODE_SYNCED;
        repeat (100 * TC) @(posedge pclk);
        chk("synced wait", 1'b0, tx_busy);
        angle <= 12'h2b7;
        upd <= 1'b1;
        @(posedge pclk);
        upd <= 1'b0;
        repeat (10 * TC) @(posedge pclk);
        chk("synced busy", 1'b1, tx_busy);
        chk("synced angle", 12'h2b7, sent_angle);
        quiet_off();
    endtask

    // triggered modes: a long low answers; a short request is stretched by the host and answers too
    task automatic t_trig();
        logic tx, dg;
        angle <= 12'h5a3;
        upd <= 1'b1;
        @(posedge pclk);
        upd <= 1'b0;
        pulse(3, 60, tx, dg);
        chk("trig answer", 1, tx);
        chk("trig angle", 12'h5a3, sent_angle);
        angle <= 12'h1e6;
        upd <= 1'b1;
        @(posedge pclk);
        upd <= 1'b0;
        pulse(4, 20, tx, dg);
        chk("fall answer", 1, tx);
        chk("fall angle", 12'h1e6, sent_angle);
        pulse(3, 10, tx, dg);
        chk("short trig", 1, tx);
    endtask

    // register readback and unmapped access
    task automatic t_apb();
        logic [31:0] q;
        logic e;
        apb(1'b0, 12'h008, 32'h0, q, e);
        chk("unmapped err", 1, e);
        apb(1'b0, REG_STAT, 32'h0, q, e);
        chk("stat pull", 1'b0, q[0]);
        chk("stat line", 1'b1, q[1]);
        chk("stat edges", 8'h07, q[15:8]);
        apb(1'b1, REG_CMD, 32'h0, q, e);
        apb(1'b0, REG_CMD, 32'h0, q, e);
        chk("cmd", 32'h0000000a, q);
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("reset slot", 2'h0, slot_number);
        chk("reset line", 1'b1, link.line);
        t_shared();
        t_stream();
        t_trig();
        t_apb();
        stop_test();
    end
endmodule
